// file: cfr_pkg.sv
// channel filter config register package: offsets, field positions, types
// assumes an 8-bit channel address and a 20-bit data path on the micro port
package cfr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 20;

    localparam logic [7:0] OFS_NCO_CTRL = 8'h88;
    localparam logic [7:0] OFS_RS_DEC = 8'h90;
    localparam logic [7:0] OFS_RS_INT = 8'h91;
    localparam logic [7:0] OFS_RS_SCALE = 8'h92;
    localparam logic [7:0] OFS_RSVD_A = 8'h93;
    localparam logic [7:0] OFS_C5_DEC = 8'h94;
    localparam logic [7:0] OFS_C5_SCALE = 8'h95;
    localparam logic [7:0] OFS_RSVD_B = 8'h96;
    localparam logic [7:0] OFS_FIR_DEC = 8'ha0;
    localparam logic [7:0] OFS_FIR_PHASE = 8'ha1;
    localparam logic [7:0] OFS_FIR_TAPS = 8'ha2;
    localparam logic [7:0] OFS_FIR_COEF = 8'ha3;
    localparam logic [7:0] OFS_FIR_CTRL = 8'ha4;
    localparam logic [7:0] OFS_SIG_I = 8'ha5;
    localparam logic [7:0] OFS_SIG_Q = 8'ha6;
    localparam logic [7:0] OFS_ST_COUNT = 8'ha7;
    localparam logic [7:0] OFS_RAM_ST = 8'ha8;
    localparam logic [7:0] OFS_OUT_CTRL = 8'ha9;

    // nco control low bits
    localparam int NCO_BYPASS_BIT = 0;
    localparam int NCO_DITHER_LSB = 1;
    // fir control bits
    localparam int FIR_BYPASS_BIT = 10;
    localparam int FIR_SRC_BIT = 9;
    localparam int FIR_BANK_BIT = 8;
    localparam int FIR_COMEXP_BIT = 7;
    localparam int FIR_FORCE_BIT = 6;
    localparam int FIR_FMT_LSB = 4;
    // output control bits
    localparam int OUT_MAP_BIT = 9;
    localparam int OUT_WIDE_BIT = 5;
    // ram self-test bits
    localparam int RAM_EN_BIT = 0;
    localparam int RAM_CFAIL_BIT = 1;
    localparam int RAM_DFAIL_BIT = 2;

    localparam logic [1:0] FMT_FIXED = 2'h0;
    localparam logic [1:0] FMT_FLOAT8 = 2'h1;

    // exponent step weights in hundredths of a db
    localparam logic [10:0] EXP_STEP_NARROW_CDB = 11'h25a;
    localparam logic [10:0] EXP_STEP_WIDE_CDB = 11'h4b2;

    typedef enum {ST_IDLE, ST_RUN} cfr_st_state_t;

    typedef enum {FMT_SEL_FIXED, FMT_SEL_FLOAT8, FMT_SEL_FLOAT12} cfr_fmt_t;

    typedef struct packed {
        logic exp_invert;
        logic exp_weight;
        logic [4:0] quiet_scale_value;
        logic [4:0] loud_scale_value;
    } cfr_rs_scale_t;

    typedef struct packed {
        logic bypass_bist;
        logic input_other;
        logic ram_bank;
        logic common_exp;
        logic force_scale;
        logic [1:0] out_format;
        logic [3:0] out_scale;
    } cfr_fir_ctrl_t;

    typedef struct packed {
        logic valid;
        logic [15:0] i_data;
        logic [15:0] q_data;
    } cfr_sample_t;
endpackage

// file: cfr_channel_filter_config_regs.sv
// channel filter configuration and status registers behind the micro port
// assumes single-cycle read/write strobes and samples on ref_clk
`timescale 1ns/1ns
module cfr_channel_filter_config_regs
    import cfr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // micro port
    input wire logic [ADDR_W-1:0] mp_addr,
    input wire logic [DATA_W-1:0] mp_wdata,
    input wire logic mp_wr,
    input wire logic mp_rd,
    output logic [DATA_W-1:0] mp_rdata,
    output logic mp_rvalid,
    // input port samples
    input wire logic [15:0] port_a_data,
    input wire logic [15:0] port_b_data,
    // filter path samples
    input wire cfr_sample_t own_comb_out,
    input wire cfr_sample_t other_comb_out,
    input wire cfr_sample_t fir_out,
    input wire cfr_sample_t chan_out,
    // ram self-test results from memories
    input wire logic coef_ram_fail,
    input wire logic data_ram_fail,
    // configuration to datapath
    output logic nco_bypass,
    output logic [1:0] dither_enable,
    output logic [15:0] xlat_i_data,
    output logic [15:0] xlat_q_data,
    output logic xlat_use_nco,
    output logic [11:0] resampler_decimation_factor,
    output logic [8:0] resampler_interpolation_factor,
    output cfr_rs_scale_t resampler_scale_out,
    output logic [10:0] exp_step_cdb,
    output logic [7:0] cic_five_decimation,
    output logic [4:0] comb_five_scale_value,
    output logic [7:0] fir_decimation_factor,
    output logic [7:0] fir_phase_select,
    output logic [7:0] fir_tap_count,
    output logic [7:0] fir_coeff_pointer,
    output cfr_fir_ctrl_t fir_ctrl_out,
    output cfr_sample_t fir_in,
    output logic coef_bank_sel,
    output logic [1:0] fmt_sel,
    output logic apply_out_scale,
    output logic out_wide,
    output logic ram_selftest_enable
);
    logic [2:0] nco_ctrl_reg;
    logic [11:0] rs_dec_reg;
    logic [8:0] rs_int_reg;
    cfr_rs_scale_t rs_scale_reg;
    logic [7:0] c5_dec_reg;
    logic [4:0] c5_scale_reg;
    logic [7:0] fir_dec_reg;
    logic [7:0] fir_phase_reg;
    logic [7:0] fir_taps_reg;
    logic [7:0] fir_coef_reg;
    cfr_fir_ctrl_t fir_ctrl_reg;
    logic [15:0] sig_i_reg;
    logic [15:0] sig_q_reg;
    logic [19:0] st_count_reg;
    logic [2:0] ram_st_reg;
    logic [9:0] out_ctrl_reg;
    cfr_st_state_t st_state_reg;
    logic [DATA_W-1:0] rdata_next;
    cfr_sample_t sig_src;
    logic wr_sig_i;
    logic wr_sig_q;
    logic wr_count;

    assign wr_sig_i = mp_wr && (mp_addr == OFS_SIG_I);
    assign wr_sig_q = mp_wr && (mp_addr == OFS_SIG_Q);
    assign wr_count = mp_wr && (mp_addr == OFS_ST_COUNT);

    // configuration writes; reserved and unused offsets store nothing
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nco_ctrl_reg <= 3'h0;
            rs_dec_reg <= 12'h000;
            rs_int_reg <= 9'h000;
            rs_scale_reg <= '0;
            c5_dec_reg <= 8'h00;
            c5_scale_reg <= 5'h00;
            fir_dec_reg <= 8'h00;
            fir_phase_reg <= 8'h00;
            fir_taps_reg <= 8'h00;
            fir_coef_reg <= 8'h00;
            fir_ctrl_reg <= '0;
            out_ctrl_reg <= 10'h000;
        end else if (mp_wr) begin
            case (mp_addr)
                OFS_NCO_CTRL: nco_ctrl_reg <= mp_wdata[2:0];
                OFS_RS_DEC: rs_dec_reg <= mp_wdata[11:0];
                OFS_RS_INT: rs_int_reg <= mp_wdata[8:0];
                OFS_RS_SCALE: rs_scale_reg <= mp_wdata[11:0];
                OFS_C5_DEC: c5_dec_reg <= mp_wdata[7:0];
                OFS_C5_SCALE: c5_scale_reg <= mp_wdata[4:0];
                OFS_FIR_DEC: fir_dec_reg <= mp_wdata[7:0];
                OFS_FIR_PHASE: fir_phase_reg <= mp_wdata[7:0];
                OFS_FIR_TAPS: fir_taps_reg <= mp_wdata[7:0];
                OFS_FIR_COEF: fir_coef_reg <= mp_wdata[7:0];
                OFS_FIR_CTRL: fir_ctrl_reg <= mp_wdata[10:0];
                OFS_OUT_CTRL: out_ctrl_reg <= mp_wdata[9:0];
                default: ;
            endcase
        end
    end

    // ram self-test: enable written, fail flags sticky until a one is written to enable
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ram_st_reg <= 3'h0;
        end else begin
            if (mp_wr && (mp_addr == OFS_RAM_ST)) begin
                ram_st_reg[RAM_EN_BIT] <= mp_wdata[RAM_EN_BIT];
            end
            // set wins over the clear from a new enable write only if enable was already on
            if (mp_wr && (mp_addr == OFS_RAM_ST) && mp_wdata[RAM_EN_BIT]) begin
                ram_st_reg[RAM_CFAIL_BIT] <= coef_ram_fail && ram_st_reg[RAM_EN_BIT];
                ram_st_reg[RAM_DFAIL_BIT] <= data_ram_fail && ram_st_reg[RAM_EN_BIT];
            end else if (ram_st_reg[RAM_EN_BIT]) begin
                if (coef_ram_fail) begin
                    ram_st_reg[RAM_CFAIL_BIT] <= 1'b1;
                end
                if (data_ram_fail) begin
                    ram_st_reg[RAM_DFAIL_BIT] <= 1'b1;
                end
            end
        end
    end

    // signature source: comb output in fir bypass, else fir or channel output
    always_comb begin
        if (fir_ctrl_reg.bypass_bist) begin
            sig_src = fir_ctrl_reg.input_other ? other_comb_out : own_comb_out;
        end else if (out_ctrl_reg[OUT_MAP_BIT]) begin
            sig_src = chan_out;
        end else begin
            sig_src = fir_out;
        end
    end

    // self-test engine: loading a nonzero count starts it, counts down per output
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_state_reg <= ST_IDLE;
            st_count_reg <= 20'h00000;
        end else if (wr_count) begin
            st_count_reg <= mp_wdata[19:0];
            st_state_reg <= (mp_wdata[19:0] != 20'h00000) ? ST_RUN : ST_IDLE;
        end else begin
            case (st_state_reg)
                ST_IDLE: ;
                ST_RUN: begin
                    if (sig_src.valid) begin
                        st_count_reg <= st_count_reg - 20'h00001;
                        if (st_count_reg == 20'h00001) begin
                            st_state_reg <= ST_IDLE;
                        end
                    end
                end
                default: st_state_reg <= ST_IDLE;
            endcase
        end
    end

    // signatures: accumulate while running, capture directly when mapped
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sig_i_reg <= 16'h0000;
            sig_q_reg <= 16'h0000;
        end else begin
            if (wr_sig_i) begin
                sig_i_reg <= mp_wdata[15:0];
            end else if (out_ctrl_reg[OUT_MAP_BIT] && sig_src.valid) begin
                sig_i_reg <= sig_src.i_data;
            end else if (st_state_reg == ST_RUN && sig_src.valid) begin
                sig_i_reg <= {sig_i_reg[14:0], sig_i_reg[15]} ^ sig_src.i_data;
            end
            if (wr_sig_q) begin
                sig_q_reg <= mp_wdata[15:0];
            end else if (out_ctrl_reg[OUT_MAP_BIT] && sig_src.valid) begin
                sig_q_reg <= sig_src.q_data;
            end else if (st_state_reg == ST_RUN && sig_src.valid) begin
                sig_q_reg <= {sig_q_reg[14:0], sig_q_reg[15]} ^ sig_src.q_data;
            end
        end
    end

    // read mux
    always_comb begin
        rdata_next = '0;
        case (mp_addr)
            OFS_NCO_CTRL: rdata_next = {17'h00000, nco_ctrl_reg};
            OFS_RS_DEC: rdata_next = {8'h00, rs_dec_reg};
            OFS_RS_INT: rdata_next = {11'h000, rs_int_reg};
            OFS_RS_SCALE: rdata_next = {8'h00, rs_scale_reg};
            OFS_C5_DEC: rdata_next = {12'h000, c5_dec_reg};
            OFS_C5_SCALE: rdata_next = {15'h0000, c5_scale_reg};
            OFS_FIR_DEC: rdata_next = {12'h000, fir_dec_reg};
            OFS_FIR_PHASE: rdata_next = {12'h000, fir_phase_reg};
            OFS_FIR_TAPS: rdata_next = {12'h000, fir_taps_reg};
            OFS_FIR_COEF: rdata_next = {12'h000, fir_coef_reg};
            OFS_FIR_CTRL: rdata_next = {9'h000, fir_ctrl_reg};
            OFS_SIG_I: rdata_next = {4'h0, sig_i_reg};
            OFS_SIG_Q: rdata_next = {4'h0, sig_q_reg};
            OFS_ST_COUNT: rdata_next = st_count_reg;
            OFS_RAM_ST: rdata_next = {17'h00000, ram_st_reg};
            OFS_OUT_CTRL: rdata_next = {10'h000, out_ctrl_reg};
            default: rdata_next = '0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mp_rdata <= '0;
            mp_rvalid <= 1'b0;
        end else begin
            mp_rdata <= mp_rd ? rdata_next : '0;
            mp_rvalid <= mp_rd;
        end
    end

    // translation stage steering
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            xlat_i_data <= 16'h0000;
            xlat_q_data <= 16'h0000;
            xlat_use_nco <= 1'b1;
        end else begin
            xlat_use_nco <= !nco_ctrl_reg[NCO_BYPASS_BIT];
            if (nco_ctrl_reg[NCO_BYPASS_BIT]) begin
                xlat_i_data <= port_a_data;
                xlat_q_data <= port_b_data;
            end else begin
                xlat_i_data <= port_a_data;
                xlat_q_data <= 16'h0000;
            end
        end
    end

    // oscillator control outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nco_bypass <= 1'b0;
            dither_enable <= 2'h0;
        end else begin
            nco_bypass <= nco_ctrl_reg[NCO_BYPASS_BIT];
            dither_enable <= nco_ctrl_reg[NCO_DITHER_LSB +: 2];
        end
    end

    // resampler rates, scale and exponent step
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            resampler_decimation_factor <= 12'h000;
            resampler_interpolation_factor <= 9'h000;
            resampler_scale_out <= '0;
            exp_step_cdb <= EXP_STEP_NARROW_CDB;
        end else begin
            resampler_decimation_factor <= rs_dec_reg;
            resampler_interpolation_factor <= rs_int_reg;
            resampler_scale_out <= rs_scale_reg;
            exp_step_cdb <= rs_scale_reg.exp_weight ? EXP_STEP_WIDE_CDB
                                                    : EXP_STEP_NARROW_CDB;
        end
    end

    // comb five and fir rates, kept in minus-one form
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cic_five_decimation <= 8'h00;
            comb_five_scale_value <= 5'h00;
            fir_decimation_factor <= 8'h00;
            fir_phase_select <= 8'h00;
            fir_tap_count <= 8'h00;
            fir_coeff_pointer <= 8'h00;
        end else begin
            cic_five_decimation <= c5_dec_reg;
            comb_five_scale_value <= c5_scale_reg;
            fir_decimation_factor <= fir_dec_reg;
            fir_phase_select <= fir_phase_reg;
            fir_tap_count <= fir_taps_reg;
            fir_coeff_pointer <= fir_coef_reg;
        end
    end

    // fir control, input source and output format
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fir_ctrl_out <= '0;
            fir_in <= '0;
            coef_bank_sel <= 1'b0;
            fmt_sel <= FMT_FIXED;
            apply_out_scale <= 1'b1;
        end else begin
            fir_ctrl_out <= fir_ctrl_reg;
            fir_in <= fir_ctrl_reg.input_other ? other_comb_out : own_comb_out;
            coef_bank_sel <= fir_ctrl_reg.ram_bank;
            fmt_sel <= fir_ctrl_reg.out_format;
            apply_out_scale <= (fir_ctrl_reg.out_format == FMT_FIXED)
                               || fir_ctrl_reg.force_scale;
        end
    end

    // output width and ram test enable
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_wide <= 1'b0;
            ram_selftest_enable <= 1'b0;
        end else begin
            out_wide <= out_ctrl_reg[OUT_WIDE_BIT];
            ram_selftest_enable <= ram_st_reg[RAM_EN_BIT];
        end
    end
endmodule

// file: cfr_cfg_asserts.sv
// checker for the channel filter config registers
// assumes it is bound into the register block top
`timescale 1ns/1ns
module cfr_cfg_asserts
    import cfr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // micro port
    input wire logic [ADDR_W-1:0] mp_addr,
    input wire logic [DATA_W-1:0] mp_wdata,
    input wire logic mp_wr,
    input wire logic mp_rd,
    input wire logic [DATA_W-1:0] mp_rdata,
    input wire logic mp_rvalid,
    // datapath side
    input wire logic [15:0] port_a_data,
    input wire logic [15:0] port_b_data,
    input wire logic [15:0] xlat_q_data,
    input wire logic nco_bypass,
    input wire logic xlat_use_nco,
    input wire logic [15:0] xlat_i_data,
    input wire cfr_rs_scale_t resampler_scale_out,
    input wire logic [10:0] exp_step_cdb,
    input wire cfr_fir_ctrl_t fir_ctrl_out,
    input wire logic coef_bank_sel,
    input wire logic [1:0] fmt_sel,
    input wire logic apply_out_scale,
    input wire logic out_wide
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_bypass_nco: assert property (xlat_use_nco == !nco_bypass)
        else $error("translation enable disagrees with bypass");
    a_bypass_route: assert property (nco_bypass |-> xlat_i_data == $past(port_a_data) &&
        xlat_q_data == $past(port_b_data)) else $error("bypass paths not ports a and b");
    a_exp_weight: assert property (exp_step_cdb == (resampler_scale_out.exp_weight ?
        EXP_STEP_WIDE_CDB : EXP_STEP_NARROW_CDB)) else $error("exponent step wrong");
    a_apply_scale: assert property (apply_out_scale ==
        (fmt_sel == FMT_FIXED || fir_ctrl_out.force_scale)) else $error("scale apply wrong");
    a_bank_sel: assert property (coef_bank_sel == fir_ctrl_out.ram_bank)
        else $error("bank select wrong");
    a_ctrl_lands: assert property (mp_wr && mp_addr == OFS_FIR_CTRL |->
        ##2 fir_ctrl_out == $past(mp_wdata[10:0], 2)) else $error("fir control not applied");
    a_scale_lands: assert property (mp_wr && mp_addr == OFS_RS_SCALE |->
        ##2 resampler_scale_out == $past(mp_wdata[11:0], 2)) else $error("scale not applied");
    a_wide_lands: assert property (mp_wr && mp_addr == OFS_OUT_CTRL |->
        ##2 out_wide == $past(mp_wdata[5], 2)) else $error("width select not applied");
    a_unused_zero: assert property (mp_rd && mp_addr inside {[8'h97:8'h9f]} |=>
        mp_rdata == 20'h0) else $error("unused offset read not zero");
    a_read_answer: assert property (mp_rd |=> mp_rvalid)
        else $error("read not answered");
    cover property (nco_bypass ##1 nco_bypass);
    cover property (fir_ctrl_out.force_scale && fmt_sel != FMT_FIXED);
    cover property (mp_rvalid && mp_rdata != 20'h0);
endmodule

bind cfr_channel_filter_config_regs cfr_cfg_asserts cfr_cfg_asserts_i (.ref_clk(ref_clk),
    .rst(rst), .mp_addr(mp_addr), .mp_wdata(mp_wdata), .mp_wr(mp_wr), .mp_rd(mp_rd),
    .mp_rdata(mp_rdata), .mp_rvalid(mp_rvalid), .port_a_data(port_a_data),
    .port_b_data(port_b_data), .xlat_q_data(xlat_q_data),
    .nco_bypass(nco_bypass), .xlat_use_nco(xlat_use_nco), .xlat_i_data(xlat_i_data),
    .resampler_scale_out(resampler_scale_out), .exp_step_cdb(exp_step_cdb),
    .fir_ctrl_out(fir_ctrl_out), .coef_bank_sel(coef_bank_sel), .fmt_sel(fmt_sel),
    .apply_out_scale(apply_out_scale), .out_wide(out_wide));

// file: cfr_host_model.sv
// host model: processor software on the micro port
// assumes the bench calls one task at a time
`timescale 1ns/1ns
module cfr_host_model
    import cfr_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // micro port
    output logic [ADDR_W-1:0] mp_addr,
    output logic [DATA_W-1:0] mp_wdata,
    output logic mp_wr,
    output logic mp_rd
);
    initial begin
        mp_addr = 8'h00;
        mp_wdata = 20'h0;
        mp_wr = 1'b0;
        mp_rd = 1'b0;
    end
    // idle address and data lines show the inverse of the address and data passed in
    task wr(input logic [7:0] a, input logic [19:0] d);
        repeat ($urandom_range(1, 0)) @(posedge ref_clk);
        @(posedge ref_clk);
        mp_addr <= a;
        mp_wdata <= (a == OFS_RSVD_A || a == OFS_RSVD_B) ? 20'h0 : d;
        mp_wr <= 1'b1;
        @(posedge ref_clk);
        mp_wr <= 1'b0;
        mp_addr <= ~a;
        mp_wdata <= ~d;
    endtask
    task rd(input logic [7:0] a);
        @(posedge ref_clk);
        mp_addr <= a;
        mp_rd <= 1'b1;
        @(posedge ref_clk);
        mp_rd <= 1'b0;
        mp_addr <= ~a;
    endtask
endmodule

// file: cfr_channel_filter_config_regs_bench.sv
// bench for the channel filter config registers
// assumes the host model and the bound checker
`timescale 1ns/1ns
module cfr_channel_filter_config_regs_bench import cfr_pkg::*;;
    logic ref_clk, rst, mp_wr, mp_rd, mp_rvalid, coef_ram_fail, data_ram_fail;
    logic nco_bypass, xlat_use_nco, apply_out_scale, ram_en_o;
    logic [11:0] rs_dec_o;
    logic [8:0] rs_int_o;
    logic [7:0] c5_dec_o, fir_dec_o, fir_ph_o, fir_tap_o, fir_coef_o;
    logic [4:0] c5_sc_o;
    logic [7:0] mp_addr;
    logic [19:0] mp_wdata, mp_rdata, v;
    logic [15:0] port_a_data, port_b_data, si, sq;
    logic [1:0] dither_enable, fmt_sel;
    logic [10:0] exp_step_cdb;
    cfr_sample_t own_comb_out, other_comb_out, fir_out, chan_out, fir_in;
    int failures, checks_done;
    logic [19:0] exp_q [$];
    logic [7:0] ofs [21] = '{8'h88, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97,
        8'h9f, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha8, 8'ha9, 8'hff};
    logic [19:0] msk [21] = '{20'h7, 20'hfff, 20'h1ff, 20'hfff, 20'h0, 20'hff, 20'h1f, 20'h0,
        20'h0, 20'h0, 20'hff, 20'hff, 20'hff, 20'hff, 20'h7ff, 20'hffff, 20'hffff, 20'hfffff,
        20'h1, 20'h3ff, 20'h0};

    cfr_host_model cfr_host_model_i (.ref_clk(ref_clk), .mp_addr(mp_addr),
        .mp_wdata(mp_wdata), .mp_wr(mp_wr), .mp_rd(mp_rd));
    cfr_channel_filter_config_regs cfr_channel_filter_config_regs_i (.ref_clk(ref_clk),
        .rst(rst), .mp_addr(mp_addr), .mp_wdata(mp_wdata), .mp_wr(mp_wr), .mp_rd(mp_rd),
        .mp_rdata(mp_rdata), .mp_rvalid(mp_rvalid), .port_a_data(port_a_data),
        .port_b_data(port_b_data), .own_comb_out(own_comb_out), .other_comb_out(other_comb_out),
        .fir_out(fir_out), .chan_out(chan_out), .coef_ram_fail(coef_ram_fail),
        .data_ram_fail(data_ram_fail), .nco_bypass(nco_bypass), .dither_enable(dither_enable),
        .xlat_i_data(), .xlat_q_data(), .xlat_use_nco(xlat_use_nco),
        .resampler_decimation_factor(rs_dec_o), .resampler_interpolation_factor(rs_int_o),
        .resampler_scale_out(), .exp_step_cdb(exp_step_cdb), .cic_five_decimation(c5_dec_o),
        .comb_five_scale_value(c5_sc_o), .fir_decimation_factor(fir_dec_o),
        .fir_phase_select(fir_ph_o), .fir_tap_count(fir_tap_o), .fir_coeff_pointer(fir_coef_o),
        .fir_ctrl_out(), .fir_in(fir_in), .coef_bank_sel(),
        .fmt_sel(fmt_sel), .apply_out_scale(apply_out_scale), .out_wide(),
        .ram_selftest_enable(ram_en_o));

    task check(input logic [19:0] got, input logic [19:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task rdx(input logic [7:0] a, input logic [19:0] e);
        exp_q.push_back(e);
        cfr_host_model_i.rd(a);
    endtask
    task settle;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // read answers taken off the queue in order
    always @(posedge ref_clk) begin
        port_a_data <= 16'($urandom);
        port_b_data <= 16'($urandom);
        if (mp_rvalid === 1'b1) begin
            if (exp_q.size() == 0) check(mp_rdata, 20'hx);
            else check(mp_rdata, exp_q.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        results();
    end
    initial begin
        rst = 1'b1;
        {own_comb_out, other_comb_out, fir_out, chan_out} = '0;
        {coef_ram_fail, data_ram_fail} = 2'b00;
        void'($urandom(32'h91ea));
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        for (int k = 0; k < 21; k++) rdx(ofs[k], 20'h0);
        check({xlat_use_nco, apply_out_scale, exp_step_cdb}, {2'b11, EXP_STEP_NARROW_CDB});
        $display("test reset values done");
        for (int k = 0; k < 21; k++) begin
            v = 20'($urandom);
            if (ofs[k] == OFS_RS_DEC) v[9] = 1'b1;
            cfr_host_model_i.wr(ofs[k], v);
            rdx(ofs[k], v & msk[k]);
            case (ofs[k])
                OFS_RS_DEC: check(20'(rs_dec_o), v & msk[k]);
                OFS_RS_INT: check(20'(rs_int_o), v & msk[k]);
                OFS_C5_DEC: check(20'(c5_dec_o), v & msk[k]);
                OFS_C5_SCALE: check(20'(c5_sc_o), v & msk[k]);
                OFS_FIR_DEC: check(20'(fir_dec_o), v & msk[k]);
                OFS_FIR_PHASE: check(20'(fir_ph_o), v & msk[k]);
                OFS_FIR_TAPS: check(20'(fir_tap_o), v & msk[k]);
                OFS_FIR_COEF: check(20'(fir_coef_o), v & msk[k]);
                OFS_RAM_ST: check(20'(ram_en_o), v & msk[k]);
                default: ;
            endcase
        end
        $display("test register table done");
        cfr_host_model_i.wr(OFS_OUT_CTRL, 20'h0);
        for (int d = 0; d < 8; d++) begin
            cfr_host_model_i.wr(OFS_NCO_CTRL, 20'(d));
            settle();
            check({dither_enable, nco_bypass}, 20'(d));
        end
        for (int f = 0; f < 8; f++) begin
            cfr_host_model_i.wr(OFS_FIR_CTRL, 20'(f << 4));
            settle();
            check(20'(apply_out_scale), 20'(f[2] || f[1:0] == 2'h0));
            check(20'(fmt_sel == FMT_FIXED), 20'(f[1:0] == 2'h0));
        end
        $display("test control fields done");
        cfr_host_model_i.wr(OFS_FIR_CTRL, 20'h0);
        cfr_host_model_i.wr(OFS_ST_COUNT, 20'h3);
        for (int n = 0; n < 5; n++) begin
            @(posedge ref_clk);
            fir_out <= {1'b1, 16'($urandom), 16'($urandom)};
            @(posedge ref_clk);
            fir_out.valid <= 1'b0;
            if (n == 1) rdx(OFS_ST_COUNT, 20'h1);
        end
        rdx(OFS_ST_COUNT, 20'h0);
        $display("test self-test count done");
        si = 16'($urandom);
        sq = 16'($urandom);
        cfr_host_model_i.wr(OFS_OUT_CTRL, 20'h200);
        @(posedge ref_clk);
        chan_out <= {1'b1, si, sq};
        @(posedge ref_clk);
        chan_out.valid <= 1'b0;
        rdx(OFS_SIG_I, {4'h0, si});
        rdx(OFS_SIG_Q, {4'h0, sq});
        $display("test output map done");
        si = 16'($urandom);
        sq = 16'($urandom);
        cfr_host_model_i.wr(OFS_FIR_CTRL, 20'h600);
        other_comb_out <= {1'b1, si, sq};
        own_comb_out <= {1'b1, ~si, ~sq};
        rdx(OFS_SIG_I, {4'h0, si});
        rdx(OFS_SIG_Q, {4'h0, sq});
        check(20'(fir_in.q_data), 20'(sq));
        {own_comb_out, other_comb_out} <= '0;
        $display("test fir bypass done");
        cfr_host_model_i.wr(OFS_RAM_ST, 20'h1);
        @(posedge ref_clk);
        data_ram_fail <= 1'b1;
        @(posedge ref_clk);
        data_ram_fail <= 1'b0;
        rdx(OFS_RAM_ST, 20'h5);
        cfr_host_model_i.wr(OFS_RAM_ST, 20'h1);
        coef_ram_fail <= 1'b1;
        @(posedge ref_clk);
        coef_ram_fail <= 1'b0;
        rdx(OFS_RAM_ST, 20'h3);
        $display("test ram self-test done");
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rdx(OFS_RS_SCALE, 20'h0);
        repeat (4) @(posedge ref_clk);
        check(20'(exp_q.size()), 20'h0);
        $display("test second reset done");
        results();
    end
endmodule
